/* File: include/tswd_pkg.sv */
// Purpose: shared constants and types of the two-stage watchdog
// Assumes: 32-bit apb data, word-aligned registers
// Notes:   offsets are byte addresses
package tswd_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [11:0] TSWD_OFF_LOAD   = 12'h000;
  localparam logic [11:0] TSWD_OFF_VALUE  = 12'h004;
  localparam logic [11:0] TSWD_OFF_CTRL   = 12'h008;
  localparam logic [11:0] TSWD_OFF_ICLR   = 12'h00c;
  localparam logic [11:0] TSWD_OFF_RIS    = 12'h010;
  localparam logic [11:0] TSWD_OFF_MIS    = 12'h014;
  localparam logic [11:0] TSWD_OFF_LOCK   = 12'h018;
  localparam logic [11:0] TSWD_OFF_IMASK  = 12'h01c;

  // ---------------------------------------------------------------
  // fields and reset values
  // ---------------------------------------------------------------
  localparam int          TSWD_CTRL_EN_BIT    = 0;
  localparam int          TSWD_CTRL_RSTEN_BIT = 1;
  localparam int          TSWD_CTRL_STALL_BIT = 2;
  // key value is arbitrary, any value other than it locks
  localparam logic [31:0] TSWD_UNLOCK_KEY     = 32'h0000a5a5;
  localparam logic [31:0] TSWD_LOAD_RST       = 32'hffffffff;
  localparam logic [31:0] TSWD_COUNT_RST      = 32'hffffffff;
  localparam logic        TSWD_MASK_RST       = 1'b1;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } tswd_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } tswd_apb_rsp_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [11:0] addr;
    logic [31:0] wdata;
  } tswd_access_t;

endpackage : tswd_pkg

/* File: src/tswd_apb_port.sv */
// Purpose: apb slave front end turning access cycles into read and write strobes
// Assumes: the owner registers every answer, one wait state per transfer
// Notes:   access strobes stand for every access cycle; the owner picks the edge
`timescale 1ns/100ps
`default_nettype none
module tswd_apb_port (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire tswd_pkg::tswd_apb_req_t req,
  output tswd_pkg::tswd_access_t       acc
);
  import tswd_pkg::*;

  // ---------------------------------------------------------------
  // access decode
  // ---------------------------------------------------------------
  // pclk/presetn kept for a future wait-state variant
  logic unused_ok;
  assign unused_ok = pclk ^ presetn;

  always_comb begin
    acc.wr    = req.psel & req.penable & req.pwrite;
    acc.rd    = req.psel & req.penable & ~req.pwrite;
    acc.addr  = {req.paddr[11:2], 2'b00};
    acc.wdata = req.pwdata;
  end

endmodule : tswd_apb_port
`default_nettype wire

/* File: src/tswd_debug_sync.sv */
// Purpose: three-stage synchroniser for the debug halt pin
// Assumes: halt comes from another clock domain
// Notes:   output changes once stages two and three agree
`timescale 1ns/100ps
`default_nettype none
module tswd_debug_sync (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic din,
  output logic      dout
);
  import tswd_pkg::*;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic q;
  } tswd_sync_state_t;

  tswd_sync_state_t st_reg;
  tswd_sync_state_t st_next;

  // ---------------------------------------------------------------
  // stages
  // ---------------------------------------------------------------
  always_comb begin
    st_next    = st_reg;
    st_next.s1 = din;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    if (st_reg.s2 == st_reg.s3) begin
      st_next.q = st_reg.s3;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign dout = st_reg.q;

endmodule : tswd_debug_sync
`default_nettype wire

/* File: src/tswd_top.sv */
// Purpose: two-stage watchdog timer with apb register access
// Assumes: single clock pclk at 250 MHz, apb master on the same clock
// Notes:   first timeout interrupts, second timeout requests system reset
`timescale 1ns/100ps
`default_nettype none

// Contract
// - 32-bit down counter loaded from load value
// - first zero sets timeout interrupt
// - enable starts counting and interrupt together
// - after first timeout reload and keep counting
// - second zero with flag pending requests reset
// - clear before second timeout reloads counter
// - load write while running reloads immediately
// - lock blocks configuration writes
// - lock state readable by software
// - interrupt clear drops the interrupt source
// - raw and masked status readable
// - load value readable
// - unlock restores configuration write access
// - load of zero interrupts at once
// - reset enable writable only while unlocked
// - debug stall freezes counter during halt
module tswd_top (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire tswd_pkg::tswd_apb_req_t apb_req,
  output tswd_pkg::tswd_apb_rsp_t      apb_rsp,
  input  wire logic                    debug_halt,
  output logic                         wdt_irq,
  output logic                         wdt_reset_req
);
  import tswd_pkg::*;

  typedef struct packed {
    logic [31:0]   load;
    logic [31:0]   count;
    logic          enable;
    logic          reset_en;
    logic          stall_en;
    logic          locked;
    logic          ris;
    logic          mask;
    logic          rst_req;
    logic          irq;
    tswd_apb_rsp_t rsp;
  } tswd_state_t;

  tswd_state_t  st_reg;
  tswd_state_t  st_next;
  tswd_access_t acc;
  logic         halt_sync;
  logic [31:0]  rdata;
  logic         decoded;
  logic         acc_first;
  logic         rd_first;
  logic         wr_fire;
  logic         wr_cfg;
  logic         wr_load;
  logic         wr_ctrl;
  logic         wr_imask;
  logic         wr_lock;
  logic         wr_iclr;
  logic         cnt_run;
  logic         cnt_zero;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  tswd_apb_port u_port (
    .pclk    (pclk),
    .presetn (presetn),
    .req     (apb_req),
    .acc     (acc)
  );

  tswd_debug_sync u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (debug_halt),
    .dout    (halt_sync)
  );

  // ---------------------------------------------------------------
  // transfer phase
  // ---------------------------------------------------------------
  // every answer leaves a flop, so each transfer takes one wait state:
  // the first access cycle registers the answer, the second shows it.
  // writes land only on the edge that ends the transfer, so a request
  // held over two access cycles is applied once
  always_comb begin
    acc_first = (acc.wr | acc.rd) & ~st_reg.rsp.pready;
    rd_first  = acc.rd & ~st_reg.rsp.pready;
    wr_fire   = acc.wr & st_reg.rsp.pready;
    wr_cfg    = wr_fire & ~st_reg.locked;
  end

  // ---------------------------------------------------------------
  // write decode
  // ---------------------------------------------------------------
  // lock and clear stay open while locked: a locked watchdog must
  // still be serviceable and unlockable
  always_comb begin
    wr_load  = wr_cfg & (acc.addr == TSWD_OFF_LOAD);
    wr_ctrl  = wr_cfg & (acc.addr == TSWD_OFF_CTRL);
    wr_imask = wr_cfg & (acc.addr == TSWD_OFF_IMASK);
    wr_lock  = wr_fire & (acc.addr == TSWD_OFF_LOCK);
    wr_iclr  = wr_fire & (acc.addr == TSWD_OFF_ICLR);
  end

  // ---------------------------------------------------------------
  // timer conditions
  // ---------------------------------------------------------------
  // a halted core freezes the count only while stall is enabled; the
  // halt reaches the counter several edges late through the synchroniser
  always_comb begin
    cnt_run  = st_reg.enable & ~(st_reg.stall_en & halt_sync);
    cnt_zero = (st_reg.count == 32'h00000000);
  end

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  always_comb begin
    rdata   = 32'h00000000;
    decoded = 1'b1;
    unique case (acc.addr)
      TSWD_OFF_LOAD: begin
        rdata = st_reg.load;
      end
      TSWD_OFF_VALUE: begin
        rdata = st_reg.count;
      end
      TSWD_OFF_CTRL: begin
        rdata[TSWD_CTRL_EN_BIT]    = st_reg.enable;
        rdata[TSWD_CTRL_RSTEN_BIT] = st_reg.reset_en;
        rdata[TSWD_CTRL_STALL_BIT] = st_reg.stall_en;
      end
      TSWD_OFF_ICLR: begin
        rdata = 32'h00000000;
      end
      TSWD_OFF_RIS: begin
        rdata[0] = st_reg.ris;
      end
      TSWD_OFF_MIS: begin
        rdata[0] = st_reg.ris & st_reg.mask;
      end
      TSWD_OFF_LOCK: begin
        rdata[0] = st_reg.locked;
      end
      TSWD_OFF_IMASK: begin
        rdata[0] = st_reg.mask;
      end
      default: begin
        decoded = 1'b0;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    logic zero_evt;
    logic clr;
    logic load_wr;
    zero_evt = 1'b0;
    clr      = 1'b0;
    load_wr  = 1'b0;
    st_next  = st_reg;

    // lock register: key unlocks, any other value locks
    if (wr_lock) begin
      st_next.locked = (acc.wdata != TSWD_UNLOCK_KEY);
    end

    if (wr_ctrl) begin
      // enable is sticky once set; only reset stops the watchdog
      if (acc.wdata[TSWD_CTRL_EN_BIT]) begin
        st_next.enable = 1'b1;
        st_next.mask   = 1'b1;
      end
      st_next.reset_en = acc.wdata[TSWD_CTRL_RSTEN_BIT];
      st_next.stall_en = acc.wdata[TSWD_CTRL_STALL_BIT];
    end

    if (wr_imask && acc.wdata[0]) begin
      st_next.mask = 1'b1; // interrupt enable is set-only
    end

    if (wr_load) begin
      load_wr      = 1'b1;
      st_next.load = acc.wdata;
    end

    // clear is accepted even when locked: servicing must work
    clr = wr_iclr;

    // ---------------- counter ----------------
    if (load_wr) begin
      st_next.count = acc.wdata;
      if (acc.wdata == 32'h00000000) begin
        zero_evt = 1'b1;
      end
    end else if (clr && st_reg.enable) begin
      st_next.count = st_reg.load;
    end else if (cnt_run) begin
      if (cnt_zero) begin
        zero_evt      = 1'b1;
        st_next.count = st_reg.load;
      end else begin
        st_next.count = st_reg.count - 32'h00000001;
      end
    end

    // ---------------- timeout flags ----------------
    if (zero_evt && st_reg.ris && st_reg.reset_en) begin
      st_next.rst_req = 1'b1;
    end

    // set wins over a clear in the same cycle
    if (zero_evt) begin
      st_next.ris = 1'b1;
    end else if (clr) begin
      st_next.ris = 1'b0;
    end

    st_next.irq = st_next.ris & st_next.mask;

    // ---------------- bus answer ----------------
    // answer fields stand for the completing cycle only, zero otherwise
    st_next.rsp.pready  = acc_first;
    st_next.rsp.pslverr = 1'b0;
    st_next.rsp.prdata  = 32'h00000000;
    if (rd_first) begin
      st_next.rsp.prdata  = rdata;
      st_next.rsp.pslverr = ~decoded;
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg             <= '0;
      st_reg.load        <= TSWD_LOAD_RST;
      st_reg.count       <= TSWD_COUNT_RST;
      st_reg.mask        <= TSWD_MASK_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // the whole answer leaves the state flop; the cost is one wait state
  assign apb_rsp       = st_reg.rsp;

  assign wdt_irq       = st_reg.irq;
  assign wdt_reset_req = st_reg.rst_req;

endmodule : tswd_top
`default_nettype wire

/* File: tb/tswd_chk_assertions.sv */
// Purpose: port-level checks of the watchdog
// Assumes: mask is set-only, so irq mirrors raw status
// Notes:   bound onto tswd_top
`timescale 1ns/100ps
`default_nettype none
module tswd_chk (
  input wire logic                    pclk,
  input wire logic                    presetn,
  input wire tswd_pkg::tswd_apb_req_t apb_req,
  input wire tswd_pkg::tswd_apb_rsp_t apb_rsp,
  input wire logic                    debug_halt,
  input wire logic                    wdt_irq,
  input wire logic                    wdt_reset_req
);
  import tswd_pkg::*;
  wire logic       acc = apb_req.psel & apb_req.penable;
  wire logic       rd  = acc & ~apb_req.pwrite;
  wire logic [9:0] wa  = apb_req.paddr[11:2];
  wire logic       clr = acc & apb_req.pwrite & (wa == TSWD_OFF_ICLR[11:2]);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_wait: assert property (acc && !apb_rsp.pready |=> apb_rsp.pready)
    else $error("pready not raised after one wait state");
  a_ready_idle: assert property (!acc |-> !apb_rsp.pready)
    else $error("pready outside access");
  a_idle_quiet: assert property (!(acc && apb_rsp.pready) |->
    apb_rsp.prdata == 32'h0 && !apb_rsp.pslverr)
    else $error("bus output outside completing cycle");
  a_err_unmapped: assert property (
    rd && apb_rsp.pready |-> apb_rsp.pslverr == (wa > 10'h7))
    else $error("pslverr wrong");
  a_wr_no_err: assert property (acc && apb_req.pwrite |-> !apb_rsp.pslverr)
    else $error("write error");
  a_raw_status: assert property (
    rd && apb_rsp.pready && wa == TSWD_OFF_RIS[11:2] |->
    apb_rsp.prdata == {31'h0, $past(wdt_irq)})
    else $error("raw status wrong");
  a_masked_status: assert property (
    rd && apb_rsp.pready && wa == TSWD_OFF_MIS[11:2] |->
    apb_rsp.prdata == {31'h0, $past(wdt_irq)})
    else $error("masked status wrong");
  a_irq_sticky: assert property (wdt_irq && !clr |=> wdt_irq)
    else $error("irq dropped");
  a_rst_sticky: assert property (wdt_reset_req |=> wdt_reset_req)
    else $error("reset dropped");
  a_rst_cause: assert property (
    $rose(wdt_reset_req) |-> wdt_irq && $past(wdt_irq))
    else $error("reset without pending irq");
endmodule : tswd_chk
bind tswd_top tswd_chk tswd_chk_inst (.pclk(pclk), .presetn(presetn), .apb_req(apb_req),
  .apb_rsp(apb_rsp), .debug_halt(debug_halt), .wdt_irq(wdt_irq),
  .wdt_reset_req(wdt_reset_req));
`default_nettype wire

/* File: tb/tswd_sys_model.sv */
// Purpose: processor side: debugger halt source, irq sink
// Assumes: halt command changes between edges
// Notes:   counts irq events seen by the interrupt controller
`timescale 1ns/100ps
`default_nettype none
module tswd_sys_model (
  input  wire logic pclk,
  input  wire logic halt_cmd,
  input  wire logic wdt_irq,
  output logic      debug_halt,
  output var int    irq_seen
);
  logic halt_q = 1'b0;
  int   n      = 0;
  // a core stops on an edge, never mid-cycle
  always @(posedge pclk) halt_q <= halt_cmd;
  always @(posedge wdt_irq) n++;
  assign debug_halt = halt_q;
  assign irq_seen   = n;
endmodule : tswd_sys_model
`default_nettype wire

/* File: tb/tswd_top_tb.sv */
// Purpose: directed register test of the watchdog
// Assumes: apb slave raises pready when its answer stands
// Notes:   small load values keep timeouts short
`timescale 1ns/100ps
`default_nettype none
`define CHK(a,b) begin comparisons++; if ((a) !== (b)) begin err_count++; \
  $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module tswd_top_tb;
  import tswd_pkg::*;
  logic          pclk     = 1'b0;
  logic          presetn  = 1'b0;
  logic          halt_cmd = 1'b0;
  tswd_apb_req_t req      = '0;
  tswd_apb_rsp_t rsp;
  logic          dh, irq, rst;
  logic [31:0]   r, v;
  logic          e;
  int            irq_seen, c;
  int            err_count   = 0;
  int            comparisons = 0;
  always #2 pclk = ~pclk;
  tswd_top tswd_top_inst (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
    .debug_halt(dh), .wdt_irq(irq), .wdt_reset_req(rst));
  tswd_sys_model tswd_sys_model_inst (.pclk(pclk), .halt_cmd(halt_cmd), .wdt_irq(irq),
    .debug_halt(dh), .irq_seen(irq_seen));
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    req.penable <= 1'b1;
    do @(posedge pclk); while (rsp.pready !== 1'b1);
    r = rsp.prdata;
    e = rsp.pslverr;
    req <= '0;
  endtask : bus
  task automatic wt(input int n);
    c = 0;
    while (irq !== 1'b1 && c < n) begin
      @(posedge pclk);
      c++;
    end
    @(negedge pclk);
  endtask : wt
  task automatic stop_test;
    $display("mismatches %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test
  initial begin
    #20000;
    err_count++;
    stop_test();
  end
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    bus(0, TSWD_OFF_LOAD, 0); `CHK(r, TSWD_LOAD_RST)
    `CHK(e, 1'b0)
    bus(0, TSWD_OFF_CTRL, 0); `CHK(r, 32'h0)
    bus(0, TSWD_OFF_LOCK, 0); `CHK(r, 32'h0)
    bus(0, TSWD_OFF_IMASK, 0); `CHK(r, {31'h0, TSWD_MASK_RST})
    bus(0, TSWD_OFF_VALUE, 0); `CHK(r, TSWD_COUNT_RST)
    bus(0, 12'h040, 0); `CHK(r, 32'h0)
    `CHK(e, 1'b1)
    bus(1, TSWD_OFF_CTRL, 32'h1);
    bus(1, TSWD_OFF_LOAD, 32'h5);
    wt(20); `CHK(c >= 4 && c <= 8, 1'b1)
    bus(0, TSWD_OFF_RIS, 0); `CHK(r, 32'h1)
    bus(0, TSWD_OFF_MIS, 0); `CHK(r, 32'h1)
    bus(0, TSWD_OFF_LOAD, 0); `CHK(r, 32'h5)
    // handler clears first, as the write may lag
    bus(1, TSWD_OFF_ICLR, 0);
    @(negedge pclk); `CHK(irq, 1'b0)
    wt(12); `CHK(c <= 8, 1'b1)
    repeat (20) @(posedge pclk);
    @(negedge pclk); `CHK(rst, 1'b0)
    `CHK(irq, 1'b1)
    bus(1, TSWD_OFF_LOCK, 0);
    bus(0, TSWD_OFF_LOCK, 0); `CHK(r, 32'h1)
    bus(1, TSWD_OFF_LOAD, 32'h77);
    bus(0, TSWD_OFF_LOAD, 0); `CHK(r, 32'h5)
    bus(1, TSWD_OFF_CTRL, 32'h2);
    bus(0, TSWD_OFF_CTRL, 0); `CHK(r, 32'h1)
    bus(1, TSWD_OFF_ICLR, 0);
    bus(0, TSWD_OFF_RIS, 0); `CHK(r, 32'h0)
    bus(1, TSWD_OFF_LOCK, TSWD_UNLOCK_KEY);
    bus(0, TSWD_OFF_LOCK, 0); `CHK(r, 32'h0)
    bus(1, TSWD_OFF_LOAD, 32'h100);
    bus(0, TSWD_OFF_VALUE, 0); `CHK(r <= 32'h100 && r >= 32'hf8, 1'b1)
    bus(1, TSWD_OFF_CTRL, 32'h5);
    halt_cmd <= 1'b1;
    repeat (8) @(posedge pclk);
    bus(0, TSWD_OFF_VALUE, 0);
    v = r;
    repeat (10) @(posedge pclk);
    bus(0, TSWD_OFF_VALUE, 0); `CHK(r, v)
    halt_cmd <= 1'b0;
    repeat (8) @(posedge pclk);
    bus(0, TSWD_OFF_VALUE, 0); `CHK(r < v, 1'b1)
    bus(1, TSWD_OFF_ICLR, 0);
    @(negedge pclk); `CHK(irq, 1'b0)
    bus(1, TSWD_OFF_LOAD, 32'h0);
    wt(3); `CHK(c <= 2, 1'b1)
    bus(1, TSWD_OFF_LOAD, 32'h8);
    bus(1, TSWD_OFF_CTRL, 32'h3);
    bus(1, TSWD_OFF_ICLR, 0);
    c = 0;
    while (rst !== 1'b1 && c < 40) begin
      @(posedge pclk);
      c++;
    end
    @(negedge pclk); `CHK(rst, 1'b1)
    `CHK(irq_seen > 0, 1'b1)
    stop_test();
  end
endmodule : tswd_top_tb
`default_nettype wire
